/* File: hdl/cpu_flags_pc_stack_regs.sv */
// Purpose: Flags, program counter, index and stack registers of a core
// Assumes: Commands arrive as APB writes; stack page held inside
// Notes:   Command register holds opcode, byte operand, word operand
`timescale 1ns/1ps
// Overview of operation
// - Seven status flags live in one byte; bit five has no flag.
// - Branch taken only on true condition, relative to PC; else next.
// - Carry bit 0 set by add carry-out, set_carry, cleared by clear.
// - Zero bit 1 set whenever a result is zero.
// - branch_if_equal on zero set, branch_if_not_equal on zero clear.
// - Interrupt-disable bit 2 set and cleared by its two commands.
// - Decimal bit 3 set by set_decimal, cleared by clear_decimal.
// - software_break sets bit 4, pushes PC then status on top.
// - software_break saves its own PC plus two as return address.
// - Overflow bit 6 on signed overflow; cleared; two branches test it.
// - mask_test may set the overflow flag.
// - Negative bit 7 on negative result; minus and plus branches.
// - Accumulator, both index registers and status are eight bits.
// - Stack lives in page 1, addresses 256 through 511.
// - Pull returns the most recent value not yet pulled.
// - Stack pointer points one below the top value.
// - Call and interrupt push return address; return pops it.
// - Indexed address is base plus index register.
// - increment_x adds one to X; transfer_a_to_x copies A to X.
module cpu_flags_pc_stack_regs #(
  parameter logic [15:0] PC_RESET     = 16'h0000,
  parameter logic [15:0] BREAK_TARGET = 16'hFF00,
  parameter logic [15:0] IRQ_TARGET   = 16'hFF80
) (
  // Clock and reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESET_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // System side
  input  wire logic        IRQ_REQ_I,
  output logic      [15:0] ADDR_BUS_O
);
  cpu_regs_pkg::core_state_t cur;
  cpu_regs_pkg::core_state_t next_cur;
  logic        busy;
  logic        write_fire;
  logic        cmd_fire;
  logic        irq_fire;
  logic [7:0]  op;
  logic [7:0]  imm;
  logic [15:0] abs16;
  logic [8:0]  sum9;
  logic [8:0]  cmp9;
  logic [7:0]  res8;
  logic        set_zn;
  logic        cond;
  logic [7:0]  sp_up;
  logic [7:0]  push_flags;
  logic [31:0] rd_mux;
  logic        mapped;

  assign op    = PWDATA_I[7:0];
  assign imm   = PWDATA_I[15:8];
  assign abs16 = PWDATA_I[31:16];
  assign busy  = (cur.seq != cpu_regs_pkg::ST_IDLE);
  assign PREADY_O   = !(PSEL_I && PENABLE_I && PWRITE_I && busy);
  assign write_fire = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
  assign cmd_fire   = write_fire && (PADDR_I == cpu_regs_pkg::ADDR_COMMAND);
  assign irq_fire   = !busy && !write_fire && cur.irq_level
                      && !cur.flags[cpu_regs_pkg::FLAG_IRQ_DIS];
  assign sp_up      = cur.sp + 8'h01;
  assign PRDATA_O   = cur.rdata;
  assign PSLVERR_O  = cur.slverr;
  assign ADDR_BUS_O = cur.bus_addr;

  // ------------------------------------------------------------
  // Register read decode
  // ------------------------------------------------------------
  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (PADDR_I)
      cpu_regs_pkg::ADDR_FLAGS:
        rd_mux = {24'h00_0000, cur.flags | 8'h20};
      cpu_regs_pkg::ADDR_PC:      rd_mux = {16'h0000, cur.pc};
      cpu_regs_pkg::ADDR_ACC:     rd_mux = {24'h00_0000, cur.acc};
      cpu_regs_pkg::ADDR_XIDX:    rd_mux = {24'h00_0000, cur.xidx};
      cpu_regs_pkg::ADDR_YIDX:    rd_mux = {24'h00_0000, cur.yidx};
      cpu_regs_pkg::ADDR_SP:      rd_mux = {24'h00_0000, cur.sp};
      cpu_regs_pkg::ADDR_COMMAND: rd_mux = 32'h0000_0000;
      cpu_regs_pkg::ADDR_STATUS:
        rd_mux = {cur.eff_addr, 14'h0000, cur.taken, busy};
      cpu_regs_pkg::ADDR_TOP:
        rd_mux = {24'h00_0000, cur.stack_mem[sp_up]};
      default: mapped = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb
  begin
    next_cur = cur;
    sum9 = 9'h000;
    cmp9 = 9'h000;
    res8 = 8'h00;
    set_zn = 1'b0;
    cond = 1'b0;
    push_flags = (cur.flags & 8'hEF) | 8'h20;
    if (cur.software_break)
    begin
      push_flags[cpu_regs_pkg::FLAG_BREAK] = 1'b1;
    end
    // Pin input: three flops, change accepted once stages two and three agree
    next_cur.irq_sync = {cur.irq_sync[1:0], IRQ_REQ_I};
    if (cur.irq_sync[1] == cur.irq_sync[2])
    begin
      next_cur.irq_level = cur.irq_sync[2];
    end
    if (PSEL_I && !PENABLE_I)
    begin
      next_cur.rdata  = PWRITE_I ? 32'h0000_0000 : rd_mux;
      next_cur.slverr = !mapped;
    end
    if (write_fire && !cmd_fire)
    begin
      case (PADDR_I)
        cpu_regs_pkg::ADDR_FLAGS: next_cur.flags = PWDATA_I[7:0] & 8'hDF;
        cpu_regs_pkg::ADDR_PC:    next_cur.pc    = PWDATA_I[15:0];
        cpu_regs_pkg::ADDR_ACC:   next_cur.acc   = PWDATA_I[7:0];
        cpu_regs_pkg::ADDR_XIDX:  next_cur.xidx  = PWDATA_I[7:0];
        cpu_regs_pkg::ADDR_YIDX:  next_cur.yidx  = PWDATA_I[7:0];
        cpu_regs_pkg::ADDR_SP:    next_cur.sp    = PWDATA_I[7:0];
        default: ;
      endcase
    end
    case (cur.seq)
      cpu_regs_pkg::ST_IDLE:
      begin
        if (irq_fire)
        begin
          next_cur.ret_addr   = cur.pc;
          next_cur.target     = IRQ_TARGET;
          next_cur.software_break        = 1'b0;
          next_cur.with_flags = 1'b1;
          next_cur.stack_mem[cur.sp] = cur.pc[15:8];
          next_cur.sp       = cur.sp - 8'h01;
          next_cur.bus_addr = {cpu_regs_pkg::STACK_PAGE, cur.sp};
          next_cur.seq      = cpu_regs_pkg::ST_PUSH_LO;
        end
        else if (cmd_fire)
        begin
          next_cur.bus_addr = cur.pc;
          next_cur.pc = cur.pc + 16'h0001;
          case (op)
            cpu_regs_pkg::OP_SET_CARRY:
              next_cur.flags[cpu_regs_pkg::FLAG_CARRY] = 1'b1;
            cpu_regs_pkg::OP_CLEAR_CARRY:
              next_cur.flags[cpu_regs_pkg::FLAG_CARRY] = 1'b0;
            cpu_regs_pkg::OP_SET_IRQ_DISABLE:
              next_cur.flags[cpu_regs_pkg::FLAG_IRQ_DIS] = 1'b1;
            cpu_regs_pkg::OP_CLEAR_IRQ_DISABLE:
              next_cur.flags[cpu_regs_pkg::FLAG_IRQ_DIS] = 1'b0;
            cpu_regs_pkg::OP_SET_DECIMAL:
              next_cur.flags[cpu_regs_pkg::FLAG_DECIMAL] = 1'b1;
            cpu_regs_pkg::OP_CLEAR_DECIMAL:
              next_cur.flags[cpu_regs_pkg::FLAG_DECIMAL] = 1'b0;
            cpu_regs_pkg::OP_CLEAR_OVERFLOW:
              next_cur.flags[cpu_regs_pkg::FLAG_OVERFL] = 1'b0;
            cpu_regs_pkg::OP_LOAD_ACCUMULATOR:
            begin
              next_cur.acc = imm;
              res8 = imm;
              set_zn = 1'b1;
              next_cur.pc = cur.pc + 16'h0002;
            end
            cpu_regs_pkg::OP_ADD_WITH_CARRY:
            begin
              sum9 = {1'b0, cur.acc} + {1'b0, imm}
                     + {8'h00, cur.flags[cpu_regs_pkg::FLAG_CARRY]};
              next_cur.acc = sum9[7:0];
              res8 = sum9[7:0];
              set_zn = 1'b1;
              next_cur.flags[cpu_regs_pkg::FLAG_CARRY] = sum9[8];
              next_cur.flags[cpu_regs_pkg::FLAG_OVERFL] =
                (cur.acc[7] == imm[7]) && (sum9[7] != cur.acc[7]);
              next_cur.pc = cur.pc + 16'h0002;
            end
            cpu_regs_pkg::OP_TRANSFER_A_TO_X:
            begin
              next_cur.xidx = cur.acc;
              res8 = cur.acc;
              set_zn = 1'b1;
            end
            cpu_regs_pkg::OP_INCREMENT_X:
            begin
              next_cur.xidx = cur.xidx + 8'h01;
              res8 = cur.xidx + 8'h01;
              set_zn = 1'b1;
            end
            cpu_regs_pkg::OP_COMPARE_X:
            begin
              cmp9 = {1'b0, cur.xidx} - {1'b0, imm};
              next_cur.flags[cpu_regs_pkg::FLAG_CARRY] = !cmp9[8];
              res8 = cmp9[7:0];
              set_zn = 1'b1;
              next_cur.pc = cur.pc + 16'h0002;
            end
            cpu_regs_pkg::OP_MASK_TEST:
            begin
              next_cur.flags[cpu_regs_pkg::FLAG_ZERO] =
                ((cur.acc & imm) == 8'h00);
              next_cur.flags[cpu_regs_pkg::FLAG_OVERFL] = imm[6];
              next_cur.flags[cpu_regs_pkg::FLAG_NEG] = imm[7];
              next_cur.pc = cur.pc + 16'h0002;
            end
            cpu_regs_pkg::OP_INDEXED_X, cpu_regs_pkg::OP_INDEXED_Y:
            begin
              next_cur.eff_addr = abs16 + {8'h00,
                op[0] ? cur.yidx : cur.xidx};
              next_cur.bus_addr = next_cur.eff_addr;
              next_cur.pc = cur.pc + 16'h0003;
            end
            cpu_regs_pkg::OP_PUSH_ACCUMULATOR:
            begin
              next_cur.stack_mem[cur.sp] = cur.acc;
              next_cur.sp = cur.sp - 8'h01;
              next_cur.bus_addr =
                {cpu_regs_pkg::STACK_PAGE, cur.sp};
            end
            cpu_regs_pkg::OP_PULL_ACCUMULATOR:
            begin
              next_cur.sp = sp_up;
              next_cur.acc = cur.stack_mem[sp_up];
              res8 = cur.stack_mem[sp_up];
              set_zn = 1'b1;
              next_cur.bus_addr = {cpu_regs_pkg::STACK_PAGE, sp_up};
            end
            cpu_regs_pkg::OP_CALL, cpu_regs_pkg::OP_SOFTWARE_BREAK:
            begin
              next_cur.software_break = (op == cpu_regs_pkg::OP_SOFTWARE_BREAK);
              next_cur.with_flags = next_cur.software_break;
              next_cur.ret_addr = next_cur.software_break
                ? cur.pc + 16'h0002
                : cur.pc + 16'h0003;
              next_cur.target = next_cur.software_break ? BREAK_TARGET : abs16;
              if (next_cur.software_break)
              begin
                next_cur.flags[cpu_regs_pkg::FLAG_BREAK] = 1'b1;
              end
              next_cur.stack_mem[cur.sp] = next_cur.ret_addr[15:8];
              next_cur.sp = cur.sp - 8'h01;
              next_cur.bus_addr = {cpu_regs_pkg::STACK_PAGE, cur.sp};
              next_cur.seq = cpu_regs_pkg::ST_PUSH_LO;
            end
            cpu_regs_pkg::OP_RETURN:
            begin
              next_cur.sp = sp_up;
              next_cur.ret_addr[7:0] = cur.stack_mem[sp_up];
              next_cur.bus_addr = {cpu_regs_pkg::STACK_PAGE, sp_up};
              next_cur.seq = cpu_regs_pkg::ST_PULL_HI;
            end
            cpu_regs_pkg::OP_RETURN_INTERRUPT:
            begin
              next_cur.sp = sp_up;
              next_cur.flags = cur.stack_mem[sp_up] & 8'hDF;
              next_cur.bus_addr = {cpu_regs_pkg::STACK_PAGE, sp_up};
              next_cur.seq = cpu_regs_pkg::ST_PULL_LO;
            end
            default:
            begin
              if (op[7:3] == cpu_regs_pkg::OP_BRANCH_IF_PLUS[7:3])
              begin
                case (op[2:1])
                  2'b00: cond = cur.flags[cpu_regs_pkg::FLAG_NEG];
                  2'b01: cond = cur.flags[cpu_regs_pkg::FLAG_OVERFL];
                  2'b10: cond = cur.flags[cpu_regs_pkg::FLAG_CARRY];
                  default: cond = cur.flags[cpu_regs_pkg::FLAG_ZERO];
                endcase
                next_cur.taken = (cond == op[0]);
                next_cur.pc = cur.pc + 16'h0002
                  + (next_cur.taken ? {{8{imm[7]}}, imm}
                                    : 16'h0000);
              end
            end
          endcase
          if (set_zn)
          begin
            next_cur.flags[cpu_regs_pkg::FLAG_ZERO] =
              (res8 == 8'h00);
            next_cur.flags[cpu_regs_pkg::FLAG_NEG] = res8[7];
          end
        end
      end
      cpu_regs_pkg::ST_PUSH_LO:
      begin
        next_cur.stack_mem[cur.sp] = cur.ret_addr[7:0];
        next_cur.sp = cur.sp - 8'h01;
        next_cur.bus_addr = {cpu_regs_pkg::STACK_PAGE, cur.sp};
        if (cur.with_flags)
        begin
          next_cur.seq = cpu_regs_pkg::ST_PUSH_FLAGS;
        end
        else
        begin
          next_cur.pc = cur.target;
          next_cur.seq = cpu_regs_pkg::ST_IDLE;
        end
      end
      cpu_regs_pkg::ST_PUSH_FLAGS:
      begin
        next_cur.stack_mem[cur.sp] = push_flags;
        next_cur.sp = cur.sp - 8'h01;
        next_cur.bus_addr = {cpu_regs_pkg::STACK_PAGE, cur.sp};
        next_cur.flags[cpu_regs_pkg::FLAG_IRQ_DIS] = 1'b1;
        next_cur.pc = cur.target;
        next_cur.seq = cpu_regs_pkg::ST_IDLE;
      end
      cpu_regs_pkg::ST_PULL_LO:
      begin
        next_cur.sp = sp_up;
        next_cur.ret_addr[7:0] = cur.stack_mem[sp_up];
        next_cur.bus_addr = {cpu_regs_pkg::STACK_PAGE, sp_up};
        next_cur.seq = cpu_regs_pkg::ST_PULL_HI;
      end
      cpu_regs_pkg::ST_PULL_HI:
      begin
        next_cur.sp = sp_up;
        next_cur.pc = {cur.stack_mem[sp_up], cur.ret_addr[7:0]};
        next_cur.bus_addr = {cpu_regs_pkg::STACK_PAGE, sp_up};
        next_cur.seq = cpu_regs_pkg::ST_IDLE;
      end
      default: next_cur.seq = cpu_regs_pkg::ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      cur       <= '0;
      cur.seq   <= cpu_regs_pkg::ST_IDLE;
      cur.flags <= cpu_regs_pkg::FLAGS_RESET;
      cur.sp    <= cpu_regs_pkg::SP_RESET;
      cur.pc    <= PC_RESET;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RESET_I);

  a_carry_set:
    assert property (cmd_fire && op == cpu_regs_pkg::OP_SET_CARRY
      |=> cur.flags[0] && cur.pc == $past(cur.pc) + 16'h0001)
    else $error("carry not set");
  a_zero_load:
    assert property (cmd_fire && op == cpu_regs_pkg::OP_LOAD_ACCUMULATOR
      |=> cur.flags[1] == (cur.acc == 8'h00))
    else $error("zero flag wrong after load");
  a_branch_equal:
    assert property (cmd_fire && op == cpu_regs_pkg::OP_BRANCH_IF_EQUAL
      && !cur.flags[1] |=> cur.pc == $past(cur.pc) + 16'h0002)
    else $error("branch taken on false condition");
  a_break_seq:
    assert property (cmd_fire && op == cpu_regs_pkg::OP_SOFTWARE_BREAK
      |=> cur.flags[4] ##2 cur.seq == cpu_regs_pkg::ST_IDLE
      && cur.pc == BREAK_TARGET && cur.stack_mem[sp_up][4]
      && cur.stack_mem[sp_up][5])
    else $error("break sequence wrong");
  a_break_return:
    assert property (cmd_fire && op == cpu_regs_pkg::OP_SOFTWARE_BREAK
      |=> cur.ret_addr == $past(cur.pc) + 16'h0002)
    else $error("break return address wrong");
  a_mask_ovf:
    assert property (cmd_fire && op == cpu_regs_pkg::OP_MASK_TEST
      |=> cur.flags[6] == $past(imm[6]))
    else $error("mask test overflow wrong");
  a_flags_bit5:
    assert property (PSEL_I && !PENABLE_I && !PWRITE_I
      && PADDR_I == cpu_regs_pkg::ADDR_FLAGS |=> PRDATA_O[5])
    else $error("bit five reads zero");
  a_push_pull:
    assert property (cmd_fire && op == cpu_regs_pkg::OP_PUSH_ACCUMULATOR
      ##3 cmd_fire && op == cpu_regs_pkg::OP_PULL_ACCUMULATOR
      |=> cur.acc == $past(cur.acc, 4) && cur.sp == $past(cur.sp, 4))
    else $error("stack not last in first out");
  a_stack_page:
    assert property (cur.seq == cpu_regs_pkg::ST_PUSH_LO
      |=> ADDR_BUS_O[15:8] == cpu_regs_pkg::STACK_PAGE)
    else $error("stack access off page one");
  a_indexed_x:
    assert property (cmd_fire && op == cpu_regs_pkg::OP_INDEXED_X
      |=> cur.eff_addr == $past(abs16) + {8'h00, $past(cur.xidx)})
    else $error("indexed address wrong");
  a_increment_x:
    assert property (cmd_fire && op == cpu_regs_pkg::OP_INCREMENT_X
      |=> cur.xidx == $past(cur.xidx) + 8'h01)
    else $error("index increment wrong");
  c_break: cover property (cmd_fire
    && op == cpu_regs_pkg::OP_SOFTWARE_BREAK ##3 !busy);
  c_branch_taken: cover property (cmd_fire && op[7:3] == 5'h02
    ##1 cur.taken);
  c_irq_entry: cover property (irq_fire);
  c_stall: cover property (!PREADY_O);
endmodule : cpu_flags_pc_stack_regs

/* File: hdl/cpu_regs_pkg.sv */
// Purpose: Constants and types of the processor register set
// Assumes: APB byte addresses, 8-bit address decode
// Notes:   Opcodes are the command codes written to the command register
package cpu_regs_pkg;
  // --------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------
  localparam logic [7:0] ADDR_FLAGS   = 8'h00;
  localparam logic [7:0] ADDR_PC      = 8'h04;
  localparam logic [7:0] ADDR_ACC     = 8'h08;
  localparam logic [7:0] ADDR_XIDX    = 8'h0C;
  localparam logic [7:0] ADDR_YIDX    = 8'h10;
  localparam logic [7:0] ADDR_SP      = 8'h14;
  localparam logic [7:0] ADDR_COMMAND = 8'h18;
  localparam logic [7:0] ADDR_STATUS  = 8'h1C;
  localparam logic [7:0] ADDR_TOP     = 8'h20;
  // --------------------------------------------------------------
  // Flag positions and reset values
  // --------------------------------------------------------------
  localparam int FLAG_CARRY   = 0;
  localparam int FLAG_ZERO    = 1;
  localparam int FLAG_IRQ_DIS = 2;
  localparam int FLAG_DECIMAL = 3;
  localparam int FLAG_BREAK   = 4;
  localparam int FLAG_UNUSED  = 5;
  localparam int FLAG_OVERFL  = 6;
  localparam int FLAG_NEG     = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h04;
  localparam logic [7:0] SP_RESET    = 8'hFF;
  localparam logic [7:0] STACK_PAGE  = 8'h01;
  // --------------------------------------------------------------
  // Command codes
  // --------------------------------------------------------------
  localparam logic [7:0] OP_SET_CARRY         = 8'h01;
  localparam logic [7:0] OP_CLEAR_CARRY       = 8'h02;
  localparam logic [7:0] OP_SET_IRQ_DISABLE   = 8'h03;
  localparam logic [7:0] OP_CLEAR_IRQ_DISABLE = 8'h04;
  localparam logic [7:0] OP_SET_DECIMAL       = 8'h05;
  localparam logic [7:0] OP_CLEAR_DECIMAL     = 8'h06;
  localparam logic [7:0] OP_CLEAR_OVERFLOW    = 8'h07;
  localparam logic [7:0] OP_LOAD_ACCUMULATOR  = 8'h08;
  localparam logic [7:0] OP_ADD_WITH_CARRY    = 8'h09;
  localparam logic [7:0] OP_TRANSFER_A_TO_X   = 8'h0A;
  localparam logic [7:0] OP_INCREMENT_X       = 8'h0B;
  localparam logic [7:0] OP_COMPARE_X         = 8'h0C;
  localparam logic [7:0] OP_MASK_TEST         = 8'h0D;
  localparam logic [7:0] OP_INDEXED_X         = 8'h0E;
  localparam logic [7:0] OP_INDEXED_Y         = 8'h0F;
  // Branches: bits 2:1 pick N,V,C,Z; bit 0 is the wanted flag value
  localparam logic [7:0] OP_BRANCH_IF_PLUS     = 8'h10;
  localparam logic [7:0] OP_BRANCH_IF_MINUS    = 8'h11;
  localparam logic [7:0] OP_BRANCH_OVERFL_CLR  = 8'h12;
  localparam logic [7:0] OP_BRANCH_OVERFL_SET  = 8'h13;
  localparam logic [7:0] OP_BRANCH_IF_NOT_EQ   = 8'h16;
  localparam logic [7:0] OP_BRANCH_IF_EQUAL    = 8'h17;
  localparam logic [7:0] OP_PUSH_ACCUMULATOR  = 8'h20;
  localparam logic [7:0] OP_PULL_ACCUMULATOR  = 8'h21;
  localparam logic [7:0] OP_CALL              = 8'h22;
  localparam logic [7:0] OP_RETURN            = 8'h23;
  localparam logic [7:0] OP_RETURN_INTERRUPT  = 8'h24;
  localparam logic [7:0] OP_SOFTWARE_BREAK    = 8'h25;
  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_PUSH_LO, ST_PUSH_FLAGS, ST_PULL_LO, ST_PULL_HI
  } seq_t;
  typedef struct packed {
    seq_t              seq;
    logic [7:0]        flags;
    logic [7:0]        acc;
    logic [7:0]        xidx;
    logic [7:0]        yidx;
    logic [7:0]        sp;
    logic [15:0]       pc;
    logic [15:0]       ret_addr;
    logic [15:0]       target;
    logic [15:0]       eff_addr;
    logic [15:0]       bus_addr;
    logic              with_flags;
    logic              software_break;
    logic              taken;
    logic [31:0]       rdata;
    logic              slverr;
    logic [2:0]        irq_sync;
    logic              irq_level;
    logic [255:0][7:0] stack_mem;
  } core_state_t;
endpackage : cpu_regs_pkg

/* File: test/sys_side_model.sv */
// Purpose: System side: interrupt source and stack page watcher
// Assumes: Request level held until the handler clears the source
// Notes:   Stack hit flag is sticky
`timescale 1ns/1ps
module sys_side_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        raise_i,
  output logic             irq_o,
  output logic             stack_seen_o
);
  initial irq_o = 1'b0;
  initial stack_seen_o = 1'b0;
  always @(posedge clk_i)
  begin
    irq_o <= raise_i;
    if (addr_i[15:8] == 8'h01)
      stack_seen_o <= 1'b1;
  end
endmodule : sys_side_model

/* File: test/testbench.sv */
// Purpose: Self-checking bench of the processor register set
// Assumes: Zero-wait APB slave except writes while busy
// Notes:   Commands go through the command register
`timescale 1ns/1ps
module testbench;
  logic        clk, rst, psel, pen, pwr, raise, pready, pslverr;
  logic        irq, seen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] abus;
  int          fails, cmp_count;
  cpu_flags_pc_stack_regs u_dut (.CLK_SYS_I(clk), .RESET_I(rst),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .IRQ_REQ_I(irq), .ADDR_BUS_O(abus));
  sys_side_model u_sys (.clk_i(clk), .addr_i(abus), .raise_i(raise),
    .irq_o(irq), .stack_seen_o(seen));
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task chk(input logic [31:0] e, input logic [31:0] s, input string n);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(e, r, n);
  endtask : rdchk
  task cmd(input logic [31:0] c);
    apb(1'b1, cpu_regs_pkg::ADDR_COMMAND, c);
  endtask : cmd
  task t_reset;
    rdchk(cpu_regs_pkg::ADDR_FLAGS, 32'h24, "flags");
    rdchk(cpu_regs_pkg::ADDR_SP, 32'hFF, "sp");
    rdchk(8'h40, 32'h0, "unmapped");
    chk(32'h1, {31'h0, pslverr}, "slverr");
    $display("test reset done");
  endtask : t_reset
  task t_flags;
    logic [7:0] op [7] = '{8'h07, 8'h01, 8'h05, 8'h03, 8'h02, 8'h06, 8'h04};
    logic [7:0] ex [7] = '{8'h20, 8'h21, 8'h29, 8'h2D, 8'h2C, 8'h24, 8'h20};
    apb(1'b1, cpu_regs_pkg::ADDR_FLAGS, 32'h40);
    for (int i = 0; i < 7; i++)
    begin
      cmd({24'h0, op[i]});
      rdchk(cpu_regs_pkg::ADDR_FLAGS, ex[i], "flags");
    end
    $display("test flags done");
  endtask : t_flags
  task t_branch;
    logic [7:0]  fl [10] = '{8'h02, 8'h02, 8'h80, 8'h80, 8'h40, 8'h40,
                             8'h01, 8'h01, 8'h00, 8'h00};
    logic [7:0]  op [10] = '{8'h17, 8'h16, 8'h11, 8'h10, 8'h13, 8'h12,
                             8'h15, 8'h14, 8'h16, 8'h17};
    logic [15:0] pc;
    pc = 16'h0100;
    apb(1'b1, cpu_regs_pkg::ADDR_PC, {16'h0, pc});
    for (int i = 0; i < 10; i++)
    begin
      apb(1'b1, cpu_regs_pkg::ADDR_FLAGS, {24'h0, fl[i]});
      cmd({16'h0, 8'h10, op[i]});
      pc = pc + ((i % 2 == 0) ? 16'h0012 : 16'h0002);
      rdchk(cpu_regs_pkg::ADDR_PC, {16'h0, pc}, "pc");
    end
    $display("test branch done");
  endtask : t_branch
  task t_index;
    cmd(32'h0508);
    cmd({24'h0, cpu_regs_pkg::OP_TRANSFER_A_TO_X});
    cmd({24'h0, cpu_regs_pkg::OP_INCREMENT_X});
    rdchk(cpu_regs_pkg::ADDR_XIDX, 32'h06, "x");
    cmd(32'h0400000E);
    apb(1'b0, cpu_regs_pkg::ADDR_STATUS, 32'h0);
    chk(32'h0406, {16'h0, r[31:16]}, "effaddr");
    chk(32'h0406, {16'h0, abus}, "addrbus");
    $display("test index done");
  endtask : t_index
  task t_irq;
    apb(1'b1, cpu_regs_pkg::ADDR_FLAGS, 32'h0);
    apb(1'b1, cpu_regs_pkg::ADDR_PC, 32'h0300);
    raise <= 1'b1;
    repeat (12) @(posedge clk);
    raise <= 1'b0;
    rdchk(cpu_regs_pkg::ADDR_PC, 32'hFF80, "pc");
    rdchk(cpu_regs_pkg::ADDR_TOP, 32'h20, "top");
    rdchk(cpu_regs_pkg::ADDR_SP, 32'hFC, "sp");
    rdchk(cpu_regs_pkg::ADDR_FLAGS, 32'h24, "flags");
    chk(32'h1, {31'h0, seen}, "stackpage");
    cmd({24'h0, cpu_regs_pkg::OP_RETURN_INTERRUPT});
    repeat (4) @(posedge clk);
    rdchk(cpu_regs_pkg::ADDR_PC, 32'h0300, "pc");
    $display("test irq done");
  endtask : t_irq
  task t_break;
    apb(1'b1, cpu_regs_pkg::ADDR_FLAGS, 32'h01);
    apb(1'b1, cpu_regs_pkg::ADDR_PC, 32'h0200);
    apb(1'b1, cpu_regs_pkg::ADDR_SP, 32'hFF);
    cmd({24'h0, cpu_regs_pkg::OP_SOFTWARE_BREAK});
    repeat (4) @(posedge clk);
    rdchk(cpu_regs_pkg::ADDR_PC, 32'hFF00, "pc");
    rdchk(cpu_regs_pkg::ADDR_TOP, 32'h31, "top");
    rdchk(cpu_regs_pkg::ADDR_SP, 32'hFC, "sp");
    cmd({24'h0, cpu_regs_pkg::OP_RETURN_INTERRUPT});
    repeat (4) @(posedge clk);
    rdchk(cpu_regs_pkg::ADDR_PC, 32'h0202, "pc");
    rdchk(cpu_regs_pkg::ADDR_FLAGS, 32'h31, "flags");
    $display("test break done");
  endtask : t_break
  task t_alu;
    apb(1'b1, cpu_regs_pkg::ADDR_FLAGS, 32'h0);
    apb(1'b1, cpu_regs_pkg::ADDR_XIDX, 32'h05);
    cmd(32'h7F08);
    cmd(32'h0109);
    rdchk(cpu_regs_pkg::ADDR_FLAGS, 32'hE0, "flags");
    cmd(32'h8009);
    rdchk(cpu_regs_pkg::ADDR_ACC, 32'h00, "acc");
    rdchk(cpu_regs_pkg::ADDR_FLAGS, 32'h63, "flags");
    cmd({24'h0, cpu_regs_pkg::OP_CLEAR_OVERFLOW});
    cmd(32'h400D);
    rdchk(cpu_regs_pkg::ADDR_FLAGS, 32'h63, "flags");
    cmd(32'h060C);
    rdchk(cpu_regs_pkg::ADDR_FLAGS, 32'hE0, "flags");
    $display("test alu done");
  endtask : t_alu
  task t_stack;
    apb(1'b1, cpu_regs_pkg::ADDR_FLAGS, 32'h0);
    cmd(32'h8108);
    cmd({24'h0, cpu_regs_pkg::OP_PUSH_ACCUMULATOR});
    cmd(32'h4208);
    cmd({24'h0, cpu_regs_pkg::OP_PUSH_ACCUMULATOR});
    cmd({24'h0, cpu_regs_pkg::OP_PULL_ACCUMULATOR});
    rdchk(cpu_regs_pkg::ADDR_ACC, 32'h42, "acc");
    cmd({24'h0, cpu_regs_pkg::OP_PULL_ACCUMULATOR});
    rdchk(cpu_regs_pkg::ADDR_ACC, 32'h81, "acc");
    rdchk(cpu_regs_pkg::ADDR_FLAGS, 32'hA0, "flags");
    apb(1'b1, cpu_regs_pkg::ADDR_PC, 32'h0400);
    cmd(32'h0600_0022);
    rdchk(cpu_regs_pkg::ADDR_PC, 32'h0600, "pc");
    rdchk(cpu_regs_pkg::ADDR_TOP, 32'h03, "top");
    cmd({24'h0, cpu_regs_pkg::OP_RETURN});
    rdchk(cpu_regs_pkg::ADDR_PC, 32'h0403, "pc");
    rdchk(cpu_regs_pkg::ADDR_SP, 32'hFF, "sp");
    $display("test stack done");
  endtask : t_stack
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #20000;
    fails++;
    results();
  end
  initial
  begin
    {rst, psel, pen, pwr, raise, paddr, pwdata} = '0;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_flags();
    t_branch();
    t_index();
    t_irq();
    t_break();
    t_alu();
    t_stack();
    results();
  end
endmodule : testbench
